/* File: verilog/tsr_router.v */
// Purpose: pulls converter samples out of two serial input streams
// Assumes: serial pins synchronous to clk, sclk well below clk/2
// Notes: main words go through a fifo, bypass and tracking are strobed
//
// Contract
// - tdm main converter samples located by main select field of data select reg
// - tdm tracking sample located by tracking select field of port control reg
// - tdm bypass samples located by bypass select field of data select reg
// - bypass select picks four consecutive slots, input one for 0-3, two for 4-7
// - tracking 0-3 takes low bits of three consecutive slots of input one
// - tracking 4 uses mask bits; 5 to 7 are reserved, never programmed
// - lj or i2s: input one feeds converters one, two; input two three, four
// - lj or i2s: tracking converter gets no data, controller powers it off
// - slots are 32 bits, sample msb first, left justified
// - masked selection: a slot feeds tracking only when its mask bit is 0
// - several unmasked: lowest slot of input one wins, then input two
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "tsr_defs.vh"

module tsr_router (
  input wire clk,
  input wire rst_b,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire sclk,
  input wire frame_sync,
  input wire serial_input_one,
  input wire serial_input_two,
  output wire [25:0] main_data,
  output wire main_valid,
  input wire main_ready,
  output reg [25:0] bypass_data,
  output reg bypass_strobe,
  output reg [23:0] tracking_data,
  output reg tracking_strobe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PUSH_A = 3'b010;
  localparam [2:0] ST_PUSH_B = 3'b100;

  reg [5:0] sel_reg;
  reg [5:0] ctl_reg;
  reg [31:0] mask_reg;
  reg ovf_reg;
  reg sclk_last_reg;
  reg fs_last_reg;
  reg lock_reg;
  reg [4:0] cnt_reg;
  reg [3:0] slot_reg;
  reg [30:0] sh_one_reg;
  reg [30:0] sh_two_reg;
  reg [31:0] word_one_reg;
  reg [31:0] word_two_reg;
  reg [3:0] wslot_reg;
  reg done_reg;
  reg [23:0] trk_acc_reg;
  reg [2:0] push_state_reg;
  reg [25:0] push_a_reg;
  reg [25:0] push_b_reg;
  reg [7:0] rdata_next;
  reg [4:0] win_idx;
  reg win_any;
  integer i;

  wire [2:0] main_sel;
  wire [2:0] byp_sel;
  wire [2:0] trk_sel;
  wire [1:0] mode;
  wire is_tdm;
  wire is_lj;
  wire sclk_rise;
  wire start;
  wire chan;
  wire fifo_ready;
  wire [31:0] main_word;
  wire main_hit;
  wire byp_hit;
  wire [31:0] byp_word;
  wire trk_group_hit;
  wire win_hit;
  wire [31:0] win_word;
  wire trk_on;

  assign main_sel = sel_reg[`TSR_MAIN_SEL];
  assign byp_sel = sel_reg[`TSR_BYP_SEL];
  assign trk_sel = ctl_reg[`TSR_TRK_SEL];
  assign mode = ctl_reg[`TSR_MODE];
  assign is_tdm = (mode == `TSR_MODE_TDM);
  assign is_lj = (mode == `TSR_MODE_LJ);

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always @* begin
    case (reg_addr)
      `TSR_ADDR_DATA_SEL: rdata_next = {2'h0, sel_reg};
      `TSR_ADDR_PORT_CTL: rdata_next = {2'h0, ctl_reg};
      `TSR_ADDR_MASK_1A: rdata_next = mask_reg[7:0];
      `TSR_ADDR_MASK_1B: rdata_next = mask_reg[15:8];
      `TSR_ADDR_MASK_2A: rdata_next = mask_reg[23:16];
      `TSR_ADDR_MASK_2B: rdata_next = mask_reg[31:24];
      `TSR_ADDR_STATUS: rdata_next = {win_idx, win_any, lock_reg, ovf_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= `TSR_SEL_RESET;
      ctl_reg <= `TSR_CTL_RESET;
      mask_reg <= `TSR_MASK_RESET;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
      if (reg_wr) begin
        case (reg_addr)
          `TSR_ADDR_DATA_SEL: sel_reg <= reg_wdata[5:0];
          `TSR_ADDR_PORT_CTL: ctl_reg <= reg_wdata[5:0];
          `TSR_ADDR_MASK_1A: mask_reg[7:0] <= reg_wdata;
          `TSR_ADDR_MASK_1B: mask_reg[15:8] <= reg_wdata;
          `TSR_ADDR_MASK_2A: mask_reg[23:16] <= reg_wdata;
          `TSR_ADDR_MASK_2B: mask_reg[31:24] <= reg_wdata;
          default: sel_reg <= sel_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // mask priority
  // ----------------------------------------
  // bit n of the mask is slot n mod 16; bits 16 up belong to input two.
  // scanning downward leaves the lowest cleared bit as winner.
  always @* begin
    win_idx = 5'h00;
    win_any = 1'b0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (!mask_reg[i]) begin
        win_idx = i[4:0];
        win_any = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // serial deframing
  // ----------------------------------------
  assign sclk_rise = sclk & ~sclk_last_reg;
  // tdm frames open on a rising sync; lj and i2s restart on either edge
  assign start = is_tdm ? (frame_sync & ~fs_last_reg) : (frame_sync ^ fs_last_reg);
  // left half is sync high in lj and sync low in i2s
  assign chan = is_lj ? ~frame_sync : frame_sync;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_last_reg <= 1'b0;
      fs_last_reg <= 1'b0;
      lock_reg <= 1'b0;
      cnt_reg <= 5'h00;
      slot_reg <= 4'h0;
      sh_one_reg <= 31'h00000000;
      sh_two_reg <= 31'h00000000;
      word_one_reg <= 32'h00000000;
      word_two_reg <= 32'h00000000;
      wslot_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      sclk_last_reg <= sclk;
      done_reg <= 1'b0;
      if (sclk_rise) begin
        fs_last_reg <= frame_sync;
        if (start) begin
          lock_reg <= 1'b1;
          slot_reg <= is_tdm ? 4'h0 : {3'h0, chan};
          if (is_lj) begin
            // lj msb already sits on the sync edge
            sh_one_reg <= {sh_one_reg[29:0], serial_input_one};
            sh_two_reg <= {sh_two_reg[29:0], serial_input_two};
            cnt_reg <= 5'h01;
          end else begin
            cnt_reg <= 5'h00;
          end
        end else if (lock_reg) begin
          sh_one_reg <= {sh_one_reg[29:0], serial_input_one};
          sh_two_reg <= {sh_two_reg[29:0], serial_input_two};
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == `TSR_BIT_LAST) begin
            word_one_reg <= {sh_one_reg, serial_input_one};
            word_two_reg <= {sh_two_reg, serial_input_two};
            wslot_reg <= slot_reg;
            slot_reg <= slot_reg + 4'h1;
            done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // slot routing
  // ----------------------------------------
  assign main_word = main_sel[2] ? word_two_reg : word_one_reg;
  assign main_hit = is_tdm ? (wslot_reg[3:2] == main_sel[1:0])
                           : (wslot_reg[3:1] == 3'h0);
  assign byp_word = byp_sel[2] ? word_two_reg : word_one_reg;
  assign byp_hit = is_tdm & (wslot_reg[3:2] == byp_sel[1:0]);
  assign trk_group_hit = (wslot_reg[3:2] == trk_sel[1:0]);
  assign win_hit = win_any & (wslot_reg == win_idx[3:0]);
  assign win_word = win_idx[4] ? word_two_reg : word_one_reg;
  // no tracking data outside tdm, nor while the converter is off
  assign trk_on = is_tdm & ~ctl_reg[`TSR_PWR_OFF];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_data <= 26'h0000000;
      bypass_strobe <= 1'b0;
      tracking_data <= 24'h000000;
      tracking_strobe <= 1'b0;
      trk_acc_reg <= 24'h000000;
    end else begin
      bypass_strobe <= 1'b0;
      tracking_strobe <= 1'b0;
      if (done_reg && byp_hit) begin
        bypass_data <= {wslot_reg[1:0], byp_word[31:8]};
        bypass_strobe <= 1'b1;
      end
      if (done_reg && trk_on) begin
        if (!trk_sel[2] && trk_group_hit) begin
          case (wslot_reg[1:0])
            `TSR_BYTE_HI: trk_acc_reg[23:16] <= word_one_reg[7:0];
            `TSR_BYTE_MID: trk_acc_reg[15:8] <= word_one_reg[7:0];
            `TSR_BYTE_LO: begin
              tracking_data <= {trk_acc_reg[23:8], word_one_reg[7:0]};
              tracking_strobe <= 1'b1;
            end
            default: trk_acc_reg <= trk_acc_reg;
          endcase
        end else if (trk_sel == `TSR_TRK_MASKED && win_hit) begin
          tracking_data <= win_word[31:8];
          tracking_strobe <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // fifo feed
  // ----------------------------------------
  // lj and i2s finish both inputs at once, so the second word waits a
  // cycle; a new main slot arriving before the feed drains counts as overflow.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      push_state_reg <= ST_IDLE;
      push_a_reg <= 26'h0000000;
      push_b_reg <= 26'h0000000;
      ovf_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `TSR_ADDR_STATUS && reg_wdata[`TSR_STAT_OVF]) begin
        ovf_reg <= 1'b0;
      end
      case (push_state_reg)
        ST_IDLE: begin
          if (done_reg && main_hit) begin
            push_state_reg <= ST_PUSH_A;
            if (is_tdm) begin
              push_a_reg <= {wslot_reg[1:0], main_word[31:8]};
            end else begin
              push_a_reg <= {1'b0, wslot_reg[0], word_one_reg[31:8]};
              push_b_reg <= {1'b1, wslot_reg[0], word_two_reg[31:8]};
            end
          end
        end
        ST_PUSH_A: begin
          if (fifo_ready) begin
            push_state_reg <= is_tdm ? ST_IDLE : ST_PUSH_B;
            push_a_reg <= push_b_reg;
          end
        end
        ST_PUSH_B: begin
          if (fifo_ready) begin
            push_state_reg <= ST_IDLE;
          end
        end
        default: push_state_reg <= ST_IDLE;
      endcase
      // set wins over a same-cycle clear
      if (done_reg && main_hit && push_state_reg != ST_IDLE) begin
        ovf_reg <= 1'b1;
      end
    end
  end

  tsr_fifo #(
    .WIDTH(`TSR_WORD_W),
    .DEPTH(`TSR_FIFO_DEPTH),
    .AW(`TSR_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(push_a_reg),
    .in_valid(push_state_reg != ST_IDLE),
    .in_ready(fifo_ready),
    .out_data(main_data),
    .out_valid(main_valid),
    .out_ready(main_ready)
  );

endmodule

/* File: verilog/tsr_defs.vh */
// Purpose: shared constants of the tdm slot source router
// Assumes: included by the router and its fifo
// Notes: register indices, field ranges, modes, reset values
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define TSR_ADDR_DATA_SEL 3'h0
`define TSR_ADDR_PORT_CTL 3'h1
`define TSR_ADDR_MASK_1A 3'h2
`define TSR_ADDR_MASK_1B 3'h3
`define TSR_ADDR_MASK_2A 3'h4
`define TSR_ADDR_MASK_2B 3'h5
`define TSR_ADDR_STATUS 3'h6

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TSR_MAIN_SEL 2:0
`define TSR_BYP_SEL 5:3
`define TSR_TRK_SEL 2:0
`define TSR_MODE 4:3
`define TSR_PWR_OFF 5
`define TSR_SEL_RESET 6'h00
`define TSR_CTL_RESET 6'h00
`define TSR_MASK_RESET 32'hffffffff
`define TSR_STAT_OVF 0

// ----------------------------------------
// modes and codes
// ----------------------------------------
`define TSR_MODE_TDM 2'h0
`define TSR_MODE_LJ 2'h1
`define TSR_MODE_I2S 2'h2
`define TSR_TRK_MASKED 3'h4
`define TSR_BYTE_HI 2'h0
`define TSR_BYTE_MID 2'h1
`define TSR_BYTE_LO 2'h2
`define TSR_BIT_LAST 5'h1f
`define TSR_WORD_W 26
`define TSR_FIFO_DEPTH 16
`define TSR_FIFO_AW 4

`endif

/* File: verilog/tsr_fifo.v */
// Purpose: small fifo for routed main-converter words
// Assumes: one clock, read data taken from a register
// Notes: out stage holds one word beyond the array
`timescale 1ns/1ps
`include "tsr_defs.vh"

module tsr_fifo #(
  parameter WIDTH = `TSR_WORD_W,
  parameter DEPTH = `TSR_FIFO_DEPTH,
  parameter AW = `TSR_FIFO_AW
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  localparam [AW:0] FULL_COUNT = DEPTH;
  localparam [AW:0] NONE = 0;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire load;

  assign in_ready = (count_reg < FULL_COUNT);
  assign push = in_valid & in_ready;
  assign load = (count_reg != NONE) & (~out_valid | out_ready);

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= NONE;
      out_data <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr_reg];
        out_valid <= 1'b1;
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      case ({push, load})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule

/* File: verification/tsr_source_model.sv */
// Purpose: controller side that sends tdm frames into the router
// Assumes: one frame per go pulse, bit clock at a quarter of clk
// Notes: bit clock stands still between frames, idle data toggles
`timescale 1ns/1ps
module tsr_source_model (
  input wire clk,
  input wire go,
  input wire [31:0] w1 [16],
  input wire [31:0] w2 [16],
  output logic sclk,
  output logic frame_sync,
  output logic serial_input_one,
  output logic serial_input_two,
  output logic busy
);
  logic [1:0] ph;
  int cnt;
  initial begin
    sclk = 1'b0;
    frame_sync = 1'b0;
    serial_input_one = 1'b0;
    serial_input_two = 1'b1;
    busy = 1'b0;
    ph = 2'h0;
    cnt = 0;
  end
  // ----------------------------------------
  // frame generator
  // ----------------------------------------
  always @(posedge clk) begin
    if (!busy) begin
      // released lines must not keep the last bit
      serial_input_one <= ~serial_input_one;
      serial_input_two <= ~serial_input_two;
      if (go) begin
        busy <= 1'b1;
        frame_sync <= 1'b1;
        cnt <= -1;
        ph <= 2'h0;
      end
    end else begin
      ph <= ph + 2'h1;
      sclk <= (ph == 2'h1 || ph == 2'h2);
      if (ph == 2'h3) begin
        cnt <= cnt + 1;
        frame_sync <= 1'b0;
        if (cnt == 511)
          busy <= 1'b0;
        else begin
          serial_input_one <= w1[(cnt + 1) / 32][31 - (cnt + 1) % 32];
          serial_input_two <= w2[(cnt + 1) / 32][31 - (cnt + 1) % 32];
        end
      end
    end
  end
endmodule

/* File: verification/tsr_router_props.sv */
// Purpose: port checks of the slot router
// Assumes: shadows follow register writes seen at the port
// Notes: configuration is kept still while frames run
`timescale 1ns/1ps
`include "tsr_defs.vh"
module tsr_router_props (
  input wire clk,
  input wire rst_b,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [25:0] main_data,
  input wire main_valid,
  input wire main_ready,
  input wire bypass_strobe,
  input wire tracking_strobe
);
  logic [5:0] sel_reg;
  logic [5:0] ctl_reg;
  logic [31:0] msk_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= `TSR_SEL_RESET;
      ctl_reg <= `TSR_CTL_RESET;
      msk_reg <= `TSR_MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `TSR_ADDR_DATA_SEL) sel_reg <= reg_wdata[5:0];
      if (reg_addr == `TSR_ADDR_PORT_CTL) ctl_reg <= reg_wdata[5:0];
      if (reg_addr >= `TSR_ADDR_MASK_1A && reg_addr <= `TSR_ADDR_MASK_2B)
        msk_reg[8 * (reg_addr - 3'h2) +: 8] <= reg_wdata;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_ctl_rd; $past(reg_rd && reg_addr == 3'h1) |-> reg_rdata == {2'h0, $past(ctl_reg)};
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("port control readback");
  property p_sel_rd; $past(reg_rd && reg_addr == 3'h0) |-> reg_rdata == {2'h0, $past(sel_reg)};
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("data select readback");
  property p_trk_gate; tracking_strobe |-> !ctl_reg[5] && ctl_reg[2:0] <= 3'h4; endproperty
  a_trk_gate: assert property (p_trk_gate) else $error("tracking while off");
  property p_tdm_only; bypass_strobe || tracking_strobe |-> ctl_reg[4:3] == 2'h0; endproperty
  a_tdm_only: assert property (p_tdm_only) else $error("strobe outside tdm");
  property p_mask_gate; tracking_strobe && ctl_reg[2:0] == 3'h4 |-> msk_reg != 32'hffffffff;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked slot taken");
  property p_slot_len; bypass_strobe |=> !bypass_strobe [*8]; endproperty
  a_slot_len: assert property (p_slot_len) else $error("slots too close");
  property p_main_hold; main_valid && !main_ready |=> main_valid && $stable(main_data);
  endproperty
  a_main_hold: assert property (p_main_hold) else $error("main word not held");
  c_bypass: cover property (bypass_strobe);
  c_masked: cover property (tracking_strobe && ctl_reg[2:0] == 3'h4);
  c_stall: cover property (main_valid && !main_ready);
endmodule
bind tsr_router tsr_router_props tsr_router_props_i (.*);

/* File: verification/test_tsr_router.sv */
// Purpose: self-checking bench of the slot router
// Assumes: model sends one tdm frame per call, config still meanwhile
// Notes: the feed stage may hold one word, so 17 or 18 words survive
`timescale 1ns/1ps
`include "tsr_defs.vh"
module test_tsr_router;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic main_ready = 1'b1;
  logic go = 1'b0;
  wire [7:0] reg_rdata;
  wire [25:0] main_data;
  wire [25:0] bypass_data;
  wire [23:0] tracking_data;
  wire sclk, frame_sync, serial_input_one, serial_input_two, busy;
  wire main_valid, bypass_strobe, tracking_strobe;
  logic [31:0] w1 [16];
  logic [31:0] w2 [16];
  logic [25:0] mq[$];
  logic [25:0] bq[$];
  logic [23:0] tq[$];
  int num_errors = 0;
  int n_compared = 0;
  tsr_router tsr_router_i (.*);
  tsr_source_model tsr_source_model_i (.*);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (main_valid && main_ready) mq.push_back(main_data);
    if (bypass_strobe) bq.push_back(bypass_data);
    if (tracking_strobe) tq.push_back(tracking_data);
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [63:0] e, input logic [63:0] s, input string n);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task frame(input int f);
    for (int k = 0; k < 16; k++) begin
      w1[k] = {4'h1, 4'(k), 8'(f), 8'h5a, 4'hc, 4'(k)};
      w2[k] = {4'h2, 4'(k), 8'(f), 8'ha5, 4'h3, 4'(k)};
    end
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    #1;
    for (int k = 0; k < 4000 && busy; k++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task t_regs;
    logic [7:0] v;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      chk((a >= 2 && a <= 5) ? 8'hff : 8'h00, v, "reset value");
    end
    wr(`TSR_ADDR_PORT_CTL, 8'hdc);
    rd(`TSR_ADDR_PORT_CTL, v);
    chk(8'h1c, v, "port control");
    wr(`TSR_ADDR_DATA_SEL, 8'hff);
    rd(`TSR_ADDR_DATA_SEL, v);
    chk(8'h3f, v, "data select");
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    chk(8'h00, v, "unmapped");
  endtask
  // every data select code once, main and bypass on opposite groups
  task t_route;
    logic [31:0] x;
    for (int i = 0; i < 8; i++) begin
      wr(`TSR_ADDR_DATA_SEL, {2'h0, 3'(7 - i), 3'(i)});
      wr(`TSR_ADDR_PORT_CTL, (i < 4) ? 8'(i) : 8'h04);
      wr(`TSR_ADDR_MASK_2A, ~(8'h03 << (i & 3)));
      wr(`TSR_ADDR_MASK_1B, (i == 7) ? 8'h7f : 8'hff);
      mq.delete();
      bq.delete();
      tq.delete();
      frame(i);
      chk(4, mq.size(), "main count");
      for (int k = 0; k < 4; k++) begin
        x = i[2] ? w2[4 * i[1:0] + k] : w1[4 * i[1:0] + k];
        chk({2'(k), x[31:8]}, mq[k], "main word");
        x = i[2] ? w1[4 * (3 - i[1:0]) + k] : w2[4 * (3 - i[1:0]) + k];
        chk({2'(k), x[31:8]}, bq[k], "bypass word");
      end
      if (i < 4)
        x = {8'h00, w1[4 * i][7:0], w1[4 * i + 1][7:0], w1[4 * i + 2][7:0]};
      else
        x = {8'h00, (i == 7) ? w1[15][31:8] : w2[i - 4][31:8]};
      chk(1, tq.size(), "tracking count");
      chk(x[23:0], tq[0], "tracking word");
    end
  endtask
  // sink stalls through five frames, then drains
  task t_fill;
    logic [7:0] v;
    int n;
    wr(`TSR_ADDR_DATA_SEL, 8'h00);
    wr(`TSR_ADDR_PORT_CTL, 8'h20);
    mq.delete();
    tq.delete();
    main_ready <= 1'b0;
    for (int f = 0; f < 5; f++) frame(f);
    rd(`TSR_ADDR_STATUS, v);
    chk(1, v[`TSR_STAT_OVF], "overflow");
    chk(0, tq.size(), "tracking while off");
    @(posedge clk) main_ready <= 1'b1;
    repeat (60) @(posedge clk);
    n = mq.size();
    chk(1, n >= 17 && n <= 18, "kept words");
    chk({2'h0, 4'h1, 4'h0, 8'h00, 8'h5a}, mq[0], "first kept");
    wr(`TSR_ADDR_STATUS, 8'h01);
    rd(`TSR_ADDR_STATUS, v);
    chk(0, v[`TSR_STAT_OVF], "overflow cleared");
  endtask
  // lj: sync high for one bit, so the first words land in the right half
  task t_lj;
    wr(`TSR_ADDR_DATA_SEL, 8'h00);
    wr(`TSR_ADDR_PORT_CTL, 8'h08);
    mq.delete();
    bq.delete();
    tq.delete();
    frame(9);
    chk(1, mq.size() >= 2, "lj count");
    chk({2'h1, w1[0][31:8]}, mq[0], "lj input one");
    chk({2'h3, w2[0][31:8]}, mq[1], "lj input two");
    chk(0, bq.size() + tq.size(), "lj side paths");
    wr(`TSR_ADDR_PORT_CTL, 8'h00);
  endtask
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_route();
    t_fill();
    t_lj();
    finish_test();
  end
  initial begin
    #3000000;
    num_errors++;
    finish_test();
  end
endmodule
